// File: hdl/sdsio_bank.sv
// Overview of operation
// - Fault word shows one set bit per active fault; zero means none.
// - Fault bits 0-6: memory, bus OV, module-one OC, power, temps, current.
// - Fault bits 8-15: feedback, ambient, calc temp, timing, interface, user, comm, speed.
// - Fault bits 16-19 and 21-23 assigned; bit 20 reserved, reads zero.
// - Fault bits 24-29 assigned; bits 30 and 31 reserved, read zero.
// - Warning word bits 0-4 hold warnings; other bits read zero.
// - Analog input reads as signed count -8192..8191, 8192 counts per 10 V.
// - Input word bits 0-7 hold discrete inputs 1-8, one means ON.
// - Inputs not configured application-readable read as zero.
// - Output word read returns outputs 1-5 on bits 0-4.
// - Writing one requests an output ON, zero requests it OFF.
// - Output is ON when its writable request or any assigned state is ON.
// - Writes to outputs not application-writable are ignored.
// - Instantaneous current reads signed, -25500..25500 hundredths of ampere.
// - Average current reads signed, same range and scaling.
`timescale 1ns/1ns
`include "sdsio_consts.svh"

module sdsio_bank
    import sdsio_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [31:0] fault_flags_i,
    input  wire logic [4:0]  warn_flags_i,
    input  wire logic [13:0] analog_count_i,
    input  wire logic [7:0]  din_pins_i,
    input  wire logic [4:0]  out_assign_i,
    input  wire logic [15:0] current_i,
    input  wire logic [15:0] avg_current_i,
    output logic      [4:0]  dout_o,
    output logic             irq_o
);

    sdsio_state_s q_reg;
    sdsio_state_s q_next;

    logic        req;
    logic        commit;
    logic [7:0]  adr;
    logic [31:0] fault_now;
    logic [31:0] fault_new;
    logic [4:0]  warn_new;
    logic [7:0]  din_chg;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;
    logic [31:0] rd_val;

    // Clamp a current reading to the reportable range and sign-extend it.
    function automatic logic [31:0] cur_word(input logic [15:0] raw);
        logic signed [15:0] v;
        v = raw;
        if (v > `SDSIO_CUR_MAX) begin
            v = `SDSIO_CUR_MAX;
        end else if (v < `SDSIO_CUR_MIN) begin
            v = `SDSIO_CUR_MIN;
        end
        return {{16{v[15]}}, v};
    endfunction

    // Bus request decode; a write commits on the edge where ack is seen.
    assign req       = cyc_i & stb_i;
    assign commit    = req & we_i & q_reg.ack;
    assign adr       = {adr_i[7:2], 2'b00};
    assign fault_now = fault_flags_i & `SDSIO_FAULT_MASK;
    assign fault_new = fault_now & ~q_reg.fault_prev;
    assign warn_new  = warn_flags_i & ~q_reg.warn_prev;

    // Read multiplexer; unmapped addresses and write-only registers read zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (adr)
            `SDSIO_A_FAULT:   rd_val = fault_now;
            `SDSIO_A_WARN:    rd_val = {27'h0, warn_flags_i & `SDSIO_WARN_MASK};
            `SDSIO_A_ANALOG:  rd_val = {{18{analog_count_i[13]}}, analog_count_i};
            `SDSIO_A_INPUTS:  rd_val = {24'h0, q_reg.din_st & q_reg.in_cfg};
            `SDSIO_A_OUTPUTS: rd_val = {27'h0, q_reg.dout};
            `SDSIO_A_CURRENT: rd_val = cur_word(current_i);
            `SDSIO_A_AVGCUR:  rd_val = cur_word(avg_current_i);
            `SDSIO_A_IRQSTAT: rd_val = {29'h0, q_reg.irq_stat};
            `SDSIO_A_IRQEN:   rd_val = {29'h0, q_reg.irq_en};
            `SDSIO_A_INCFG:   rd_val = {24'h0, q_reg.in_cfg};
            `SDSIO_A_OUTCFG:  rd_val = {27'h0, q_reg.out_cfg};
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    // Next-state logic for synchroniser, bus slave, outputs and interrupts.
    always_comb begin
        q_next = q_reg;
        // Three-stage pin synchroniser; a change counts when stages two and three agree.
        q_next.din_s1 = din_pins_i;
        q_next.din_s2 = q_reg.din_s1;
        q_next.din_s3 = q_reg.din_s2;
        for (int i = 0; i < 8; i++) begin
            if (q_reg.din_s2[i] == q_reg.din_s3[i]) begin
                q_next.din_st[i] = q_reg.din_s3[i];
            end
        end
        din_chg = q_next.din_st ^ q_reg.din_st;
        q_next.fault_prev = fault_now;
        q_next.warn_prev  = warn_flags_i;

        // Single-cycle ack, dropped in the cycle after it was given.
        q_next.ack = req & ~q_reg.ack;
        if (req & ~q_reg.ack & ~we_i) begin
            q_next.rdata = rd_val;
        end

        // Writable registers; writes to read-only words fall through untouched.
        irq_clr = 3'b000;
        if (commit & sel_i[0]) begin
            unique case (adr)
                `SDSIO_A_OUTPUTS: begin
                    q_next.out_req = (q_reg.out_req & ~q_reg.out_cfg)
                                   | (dat_i[4:0] & q_reg.out_cfg);
                end
                `SDSIO_A_IRQCLR: irq_clr = dat_i[2:0];
                `SDSIO_A_IRQEN:  q_next.irq_en = dat_i[2:0];
                `SDSIO_A_INCFG:  q_next.in_cfg = dat_i[7:0];
                `SDSIO_A_OUTCFG: q_next.out_cfg = dat_i[4:0];
                default: ;
            endcase
        end

        // Physical outputs merge application request with assigned states.
        q_next.dout = (q_reg.out_req & q_reg.out_cfg) | out_assign_i;

        // Sticky event bits; a new event wins over a simultaneous clear.
        irq_set = 3'b000;
        irq_set[`SDSIO_IRQ_FAULT] = |fault_new;
        irq_set[`SDSIO_IRQ_WARN]  = |(warn_new & `SDSIO_WARN_MASK);
        irq_set[`SDSIO_IRQ_INPUT] = |(din_chg & q_reg.in_cfg);
        q_next.irq_stat = (q_reg.irq_stat & ~irq_clr) | irq_set;
    end

    // State register with synchronous reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_reg         <= '0;
            q_reg.in_cfg  <= `SDSIO_INCFG_RST;
            q_reg.out_cfg <= `SDSIO_OUTCFG_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // Registered outputs; irq_o is gated from registered status and enable.
    assign dat_o  = q_reg.rdata;
    assign ack_o  = q_reg.ack;
    assign dout_o = q_reg.dout;
    assign irq_o  = |(q_reg.irq_stat & q_reg.irq_en);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Fault read returns the flags of the request cycle with reserved bits clear.
    property p_fault_read;
        req & ~we_i & ~ack_o & (adr == `SDSIO_A_FAULT)
        |=> ack_o && (dat_o == ($past(fault_flags_i) & `SDSIO_FAULT_MASK));
    endproperty
    a_fault_read: assert property (p_fault_read)
        else $error("fault word read mismatch");

    // Reserved fault bits never read as set.
    property p_fault_rsvd;
        ack_o & ~we_i & (adr == `SDSIO_A_FAULT) |-> (dat_o & `SDSIO_FAULT_RSVD) == 32'h0;
    endproperty
    a_fault_rsvd: assert property (p_fault_rsvd)
        else $error("reserved fault bit set");

    // Warning read keeps only bits 0 to 4.
    property p_warn_read;
        req & ~we_i & ~ack_o & (adr == `SDSIO_A_WARN)
        |=> dat_o == {27'h0, $past(warn_flags_i)};
    endproperty
    a_warn_read: assert property (p_warn_read)
        else $error("warning word read mismatch");

    // Analog read is the sign-extended 14-bit count.
    property p_analog;
        req & ~we_i & ~ack_o & (adr == `SDSIO_A_ANALOG)
        |=> $signed(dat_o) == $signed($past(analog_count_i));
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog count not sign extended");

    // Unconfigured inputs and upper bits read zero.
    property p_inputs;
        ack_o & ~we_i & (adr == `SDSIO_A_INPUTS)
        |-> (dat_o[31:8] == 24'h0) && ((dat_o[7:0] & ~$past(q_reg.in_cfg)) == 8'h0);
    endproperty
    a_inputs: assert property (p_inputs)
        else $error("unconfigured input read as set");

    // An output write updates only configured request bits.
    property p_out_write;
        commit & sel_i[0] & (adr == `SDSIO_A_OUTPUTS)
        |=> q_reg.out_req == (($past(q_reg.out_req) & ~$past(q_reg.out_cfg))
                             | ($past(dat_i[4:0]) & $past(q_reg.out_cfg)));
    endproperty
    a_out_write: assert property (p_out_write)
        else $error("output request not updated");

    // Any assigned state forces its output ON next cycle.
    property p_out_or;
        ##1 (dout_o & $past(out_assign_i)) == $past(out_assign_i);
    endproperty
    a_out_or: assert property (p_out_or)
        else $error("assigned output state not ON");

    // With nothing writable and nothing assigned, every output is OFF.
    property p_out_off;
        (out_assign_i == 5'h0) && (q_reg.out_cfg == 5'h0) |=> dout_o == 5'h0;
    endproperty
    a_out_off: assert property (p_out_off)
        else $error("unwritable output driven by request");

    // Current readings stay within the reportable range.
    property p_cur_range;
        ack_o & ~we_i & ((adr == `SDSIO_A_CURRENT) | (adr == `SDSIO_A_AVGCUR))
        |-> ($signed(dat_o) <= `SDSIO_CUR_LIM) && ($signed(dat_o) >= -`SDSIO_CUR_LIM);
    endproperty
    a_cur_range: assert property (p_cur_range)
        else $error("current out of range");

    // Writes to read-only words change no control state.
    property p_ro_write;
        commit & (adr <= `SDSIO_A_AVGCUR) & (adr != `SDSIO_A_OUTPUTS)
        |=> $stable(q_reg.out_req) && $stable(q_reg.in_cfg) && $stable(q_reg.irq_en);
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("read-only write changed state");

    // Every taken request is answered on the very next edge.
    property p_ack_answer;
        req & ~ack_o |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not acknowledged");

    // The acknowledge is a single-cycle pulse.
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

    // Without a request no acknowledge appears.
    property p_idle_no_ack;
        !req |=> !ack_o;
    endproperty
    a_idle_no_ack: assert property (p_idle_no_ack)
        else $error("ack without request");

    // A quiet fault word reads as all zero.
    property p_fault_zero;
        req & ~we_i & ~ack_o & (adr == `SDSIO_A_FAULT)
        & ((fault_flags_i & `SDSIO_FAULT_MASK) == 32'h0) |=> dat_o == 32'h0;
    endproperty
    a_fault_zero: assert property (p_fault_zero)
        else $error("quiet fault word not zero");

    // Reserved warning bits never read as set.
    property p_warn_rsvd;
        ack_o & ~we_i & (adr == `SDSIO_A_WARN) |-> dat_o[31:5] == 27'h0;
    endproperty
    a_warn_rsvd: assert property (p_warn_rsvd)
        else $error("reserved warning bit set");

    // Input word returns the settled readable inputs of the request cycle.
    property p_inputs_read;
        ack_o & ~we_i & (adr == `SDSIO_A_INPUTS)
        |-> dat_o[7:0] == ($past(q_reg.din_st) & $past(q_reg.in_cfg));
    endproperty
    a_inputs_read: assert property (p_inputs_read)
        else $error("input word mismatch");

    // Output word read returns the physical outputs of the request cycle.
    property p_out_read;
        ack_o & ~we_i & (adr == `SDSIO_A_OUTPUTS) |-> dat_o == {27'h0, $past(dout_o)};
    endproperty
    a_out_read: assert property (p_out_read)
        else $error("output word read mismatch");

    // An in-range instantaneous current passes through unchanged.
    property p_cur_read;
        req & ~we_i & ~ack_o & (adr == `SDSIO_A_CURRENT)
        & ($signed(current_i) <= `SDSIO_CUR_LIM) & ($signed(current_i) >= -`SDSIO_CUR_LIM)
        |=> $signed(dat_o) == $signed($past(current_i));
    endproperty
    a_cur_read: assert property (p_cur_read)
        else $error("current reading altered");

    // An in-range average current passes through unchanged.
    property p_avg_read;
        req & ~we_i & ~ack_o & (adr == `SDSIO_A_AVGCUR)
        & ($signed(avg_current_i) <= `SDSIO_CUR_LIM)
        & ($signed(avg_current_i) >= -`SDSIO_CUR_LIM)
        |=> $signed(dat_o) == $signed($past(avg_current_i));
    endproperty
    a_avg_read: assert property (p_avg_read)
        else $error("average current altered");

    // A write with byte lane zero disabled leaves the output requests alone.
    property p_sel_gate;
        commit & ~sel_i[0] |=> $stable(q_reg.out_req);
    endproperty
    a_sel_gate: assert property (p_sel_gate)
        else $error("disabled lane changed requests");

    // Writes to read-only words leave the configuration untouched.
    property p_ro_cfg;
        commit & (adr <= `SDSIO_A_AVGCUR) & (adr != `SDSIO_A_OUTPUTS)
        |=> $stable(q_reg.out_cfg);
    endproperty
    a_ro_cfg: assert property (p_ro_cfg)
        else $error("read-only write changed output config");

    // A newly raised fault always lands in the status register.
    property p_fault_event;
        fault_new != 32'h0 |=> q_reg.irq_stat[`SDSIO_IRQ_FAULT];
    endproperty
    a_fault_event: assert property (p_fault_event)
        else $error("fault event not recorded");

endmodule

// File: hdl/sdsio_consts.svh
`ifndef SDSIO_CONSTS_SVH
`define SDSIO_CONSTS_SVH

// Register byte addresses on the Wishbone bus.
`define SDSIO_A_FAULT    8'h00
`define SDSIO_A_WARN     8'h04
`define SDSIO_A_ANALOG   8'h08
`define SDSIO_A_INPUTS   8'h0C
`define SDSIO_A_OUTPUTS  8'h10
`define SDSIO_A_CURRENT  8'h14
`define SDSIO_A_AVGCUR   8'h18
`define SDSIO_A_IRQSTAT  8'h1C
`define SDSIO_A_IRQCLR   8'h20
`define SDSIO_A_IRQEN    8'h24
`define SDSIO_A_INCFG    8'h28
`define SDSIO_A_OUTCFG   8'h2C

// Defined bits of the fault and warning words; reserved bits read zero.
`define SDSIO_FAULT_MASK 32'h3FEF_FF7F
`define SDSIO_WARN_MASK  5'h1F
`define SDSIO_FAULT_RSVD 32'hC010_0080

// Current limits in hundredths of an ampere.
`define SDSIO_CUR_MAX    16'sh639C
`define SDSIO_CUR_MIN    -16'sh639C
`define SDSIO_CUR_LIM    32'sd25500

// Reset values of configuration registers.
`define SDSIO_INCFG_RST  8'hFF
`define SDSIO_OUTCFG_RST 5'h1F

// Interrupt status bit positions.
`define SDSIO_IRQ_FAULT  0
`define SDSIO_IRQ_WARN   1
`define SDSIO_IRQ_INPUT  2

`endif

// File: hdl/sdsio_pkg.sv
package sdsio_pkg;

    // Complete state of the register bank.
    typedef struct packed {
        logic [7:0]  din_s1;
        logic [7:0]  din_s2;
        logic [7:0]  din_s3;
        logic [7:0]  din_st;
        logic [31:0] fault_prev;
        logic [4:0]  warn_prev;
        logic [4:0]  out_req;
        logic [7:0]  in_cfg;
        logic [4:0]  out_cfg;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_en;
        logic        ack;
        logic [31:0] rdata;
        logic [4:0]  dout;
    } sdsio_state_s;

endpackage

// File: sim/sdsio_host.sv
`timescale 1ns/1ns

// Controller model: issues classic Wishbone single cycles and waits for ack.
module sdsio_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic      [7:0]  adr_o,
    output logic      [3:0]  sel_o,
    output logic      [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'hF;
        dat_o = 32'h0000_0000;
    end

    // One bus cycle; holds the request until ack is seen or 50 edges pass, then returns the read data.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        dat_o <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_i !== 1'b1 && n < 50);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
    endtask
endmodule

// File: sim/tb_sdsio_bank.sv
`timescale 1ns/1ns
`include "sdsio_consts.svh"

module tb_sdsio_bank;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr, din = 8'h00;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, flt = 32'h0;
    logic [4:0]  wrn = 5'h00, asg = 5'h00, dout;
    logic [13:0] ana = 14'h0000;
    logic [15:0] cur = 16'h0000, avg = 16'h0000;
    int          err_count = 0, n_checks = 0, cyc_cnt = 0;

    sdsio_bank u_sdsio_bank (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .fault_flags_i(flt), .warn_flags_i(wrn), .analog_count_i(ana),
        .din_pins_i(din), .out_assign_i(asg), .current_i(cur),
        .avg_current_i(avg), .dout_o(dout), .irq_o(irq));
    sdsio_host u_sdsio_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // Free-running clock at 125 MHz.
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // Cuts a hung run short.
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_sdsio_host.xfer(1'b1, a, d, q);
    endtask

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_sdsio_host.xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask

    task automatic t_words();
        rdc("fault", `SDSIO_A_FAULT, 32'h0000_0000);
        flt <= 32'hFFFF_FFFF;
        wrn <= 5'h1F;
        rdc("fault", `SDSIO_A_FAULT, 32'h3FEF_FF7F);
        rdc("warn", `SDSIO_A_WARN, 32'h0000_001F);
        ana <= 14'h2000;
        rdc("analog", `SDSIO_A_ANALOG, 32'hFFFF_E000);
        ana <= 14'h1FFF;
        rdc("analog", `SDSIO_A_ANALOG, 32'h0000_1FFF);
        $display("test words done");
    endtask

    task automatic t_inputs();
        din <= 8'hA5;
        repeat (6) @(posedge clk_i);
        rdc("inputs", `SDSIO_A_INPUTS, 32'h0000_00A5);
        wr(`SDSIO_A_INCFG, 32'h0000_000F);
        rdc("inputs", `SDSIO_A_INPUTS, 32'h0000_0005);
        $display("test inputs done");
    endtask

    task automatic t_outputs();
        wr(`SDSIO_A_OUTPUTS, 32'h0000_000A);
        repeat (3) @(posedge clk_i);
        chk("dout", 32'h0000_000A, {27'h0, dout});
        rdc("outputs", `SDSIO_A_OUTPUTS, 32'h0000_000A);
        asg <= 5'h11;
        repeat (3) @(posedge clk_i);
        chk("dout", 32'h0000_001B, {27'h0, dout});
        asg <= 5'h00;
        wr(`SDSIO_A_OUTCFG, 32'h0000_001C);
        wr(`SDSIO_A_OUTPUTS, 32'h0000_001F);
        repeat (3) @(posedge clk_i);
        chk("dout", 32'h0000_001C, {27'h0, dout});
        $display("test outputs done");
    endtask

    task automatic t_current();
        cur <= 16'h7530;
        avg <= 16'hC726;
        rdc("current", `SDSIO_A_CURRENT, 32'h0000_639C);
        rdc("average", `SDSIO_A_AVGCUR, 32'hFFFF_C726);
        $display("test current done");
    endtask

    task automatic t_irq();
        flt <= 32'h0000_0000;
        wr(`SDSIO_A_IRQCLR, 32'h0000_0007);
        wr(`SDSIO_A_IRQEN, 32'h0000_0001);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        flt <= 32'h0000_0010;
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rdc("irqstat", `SDSIO_A_IRQSTAT, 32'h0000_0001);
        wr(`SDSIO_A_IRQCLR, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        $display("test irq done");
    endtask

    // Mid-run reset brings the configuration back to its defaults.
    task automatic t_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("incfg", `SDSIO_A_INCFG, 32'h0000_00FF);
        rdc("outcfg", `SDSIO_A_OUTCFG, 32'h0000_001F);
        rdc("irqen", `SDSIO_A_IRQEN, 32'h0000_0000);
        chk("dout", 32'h0000_0000, {27'h0, dout});
        chk("irq", 32'h0000_0000, {31'h0, irq});
        $display("test reset done");
    endtask

    task automatic t_readonly();
        wr(`SDSIO_A_FAULT, 32'hFFFF_FFFF);
        rdc("fault", `SDSIO_A_FAULT, 32'h0000_0010);
        wr(`SDSIO_A_CURRENT, 32'h0000_0000);
        rdc("current", `SDSIO_A_CURRENT, 32'h0000_639C);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        $display("test readonly done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_words();
        t_inputs();
        t_outputs();
        t_current();
        t_irq();
        t_readonly();
        t_reset();
        close_out();
    end
endmodule
